// ==== usb_ep_consts.svh ====
// Purpose: Offsets, field positions, reset values and sizes for the bulk endpoint FIFOs.
// Assumes: Register offsets are word indexes; byte address is four times the index.
// Notes:   Definitions only; included by its bare name.
//
// Behaviour
// - Receive FIFO count reads 0 when empty up to 64 when full.
// - Writing receive flush bit empties receive FIFO; flush bit reads zero.
// - Host write into full receive FIFO sets sticky overflow, write-one clears.
// - Read of empty receive FIFO sets sticky underflow, write-one clears.
// - Receive full and empty flags follow occupancy; empty set after reset.
// - Endpoint 3 max packet size, eight bits, units of eight bytes, resets 08h.
// - Endpoint 3 max packet size is presented to the host descriptor.
// - Each CPU write to transmit data port with byte lane 0 enabled pushes one byte unless the FIFO is full.
// - Transmit FIFO bytes go to host through endpoint 4 IN reads.
// - Transmit FIFO count reads 0 when empty up to 64 when full.
// - Transmit-valid lets host IN reads proceed, then clears itself once a read flagged last is taken.
// - Transmit-valid gating applies only while extended gate bit is set.
// - Writing transmit flush bit empties transmit FIFO; flush bit reads zero.
// - CPU write into full transmit FIFO sets sticky overflow, write-one clears.
// - Transmit full and empty follow occupancy; empty after reset; bit 2 reserved.
// - Endpoint 4 max packet size, units of eight bytes, resets 64 bytes, reported.
`ifndef USB_EP_CONSTS_SVH
`define USB_EP_CONSTS_SVH

// ------------------------------------------------------------------
// Sizes
// ------------------------------------------------------------------
`define FIFO_DEPTH     7'h40
`define CNT_W          7
`define PTR_W          6
`define ADDR_W         16
`define IRQ_W          5

// ------------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------------
`define RX_DATA_IDX    16'h4020
`define RX_COUNT_IDX   16'h4022
`define RX_STATUS_IDX  16'h4024
`define RX_MAXPKT_IDX  16'h4026
`define TX_DATA_IDX    16'h4028
`define TX_COUNT_IDX   16'h402A
`define TX_STATUS_IDX  16'h402C
`define TX_MAXPKT_IDX  16'h402E
`define IRQ_STAT_IDX   16'h4040
`define IRQ_MASK_IDX   16'h4041
`define TX_GATE_IDX    16'h4042

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ST_EMPTY_BIT   0
`define ST_FULL_BIT    1
`define ST_UNF_BIT     2
`define ST_OVF_BIT     3
`define ST_FLUSH_BIT   4
`define ST_TXVLD_BIT   5
`define TX_GATE_BIT    0
`define IRQ_RX_OVF     0
`define IRQ_RX_UNF     1
`define IRQ_TX_OVF     2
`define IRQ_RX_DATA    3
`define IRQ_TX_SENT    4

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define MAXPKT_RST     8'h08

`endif

// ==== usb_ep_pkg.sv ====
// Purpose: Types shared by the bulk endpoint FIFO block and its users.
// Assumes: One clock domain.
// Notes:   Constants live in usb_ep_consts.svh.
package usb_ep_pkg;

  typedef logic [7:0] byte_t;

  // Host OUT byte offered to the receive FIFO
  typedef struct packed {
    logic  valid;
    byte_t data;
  } host_out_s;

  // Host IN byte request from the transmit FIFO
  typedef struct packed {
    logic req;
    logic last;
  } host_in_req_s;

  // Answer to an IN byte request
  typedef struct packed {
    logic  ack;
    logic  nak;
    byte_t data;
  } host_in_rsp_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage

// ==== usb_bulk_endpoint_fifos.sv ====
// Purpose: Endpoint 3 receive and endpoint 4 transmit byte FIFOs with Avalon-MM registers.
// Assumes: Host-side engine runs on clk; Avalon address is the register index.
// Notes:   Every access takes one wait cycle; unmapped reads return zero.
`timescale 1ns/1ps
`include "usb_ep_consts.svh"

// ------------------------------------------------------------------
// Byte FIFO, flip-flop storage
// ------------------------------------------------------------------
module byte_fifo (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              push,
  input  usb_ep_pkg::byte_t      push_data,
  input  wire logic              pop,
  input  wire logic              flush,
  output usb_ep_pkg::byte_t      head,
  output logic [`CNT_W-1:0]      count_q,
  output logic                   full,
  output logic                   empty
);
  import usb_ep_pkg::*;

  byte_t             mem_q [`FIFO_DEPTH];
  logic [`PTR_W-1:0] wr_ptr_q;
  logic [`PTR_W-1:0] rd_ptr_q;
  logic              do_push;
  logic              do_pop;

  assign full    = (count_q == `FIFO_DEPTH);
  assign empty   = (count_q == `CNT_W'(0));
  // Full drops the byte, empty leaves all alone
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign head    = mem_q[rd_ptr_q];

  genvar i;
  generate
    for (i = 0; i < `FIFO_DEPTH; i++) begin : g_mem
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem_q[i] <= 8'h00;
        end else if (do_push && !flush && wr_ptr_q == `PTR_W'(i)) begin
          mem_q[i] <= push_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= `PTR_W'(0);
      rd_ptr_q <= `PTR_W'(0);
    end else if (flush) begin
      wr_ptr_q <= `PTR_W'(0);
      rd_ptr_q <= `PTR_W'(0);
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + `PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + `PTR_W'(1);
      end
    end
  end

  // Flush wins over a push in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= `CNT_W'(0);
    end else if (flush) begin
      count_q <= `CNT_W'(0);
    end else if (do_push && !do_pop) begin
      count_q <= count_q + `CNT_W'(1);
    end else if (do_pop && !do_push) begin
      count_q <= count_q - `CNT_W'(1);
    end
  end

endmodule

// ------------------------------------------------------------------
// Top: endpoint FIFOs and register file
// ------------------------------------------------------------------
module usb_bulk_endpoint_fifos (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`ADDR_W-1:0]    avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       irq,
  input  usb_ep_pkg::host_out_s      host_out,
  output logic                       host_out_nak,
  input  usb_ep_pkg::host_in_req_s   host_in_req,
  output usb_ep_pkg::host_in_rsp_s   host_in_rsp,
  output usb_ep_pkg::byte_t          ep3_max_pkt,
  output usb_ep_pkg::byte_t          ep4_max_pkt
);
  import usb_ep_pkg::*;

  function automatic logic is_reg(input logic [`ADDR_W-1:0] a,
                                  input logic [`ADDR_W-1:0] idx);
    is_reg = (a == idx);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_e         bus_q;
  logic               commit;
  logic               wr_commit;
  logic               rd_commit;
  byte_t              wbyte;
  byte_t              rd_byte;
  logic [31:0]        readdata_q;
  logic               waitrequest_q;

  byte_t              rx_head;
  logic [`CNT_W-1:0]  rx_count;
  logic               rx_full;
  logic               rx_empty;
  logic               rx_pop;
  logic               rx_flush;
  logic               rx_ovf_ev;
  logic               rx_unf_ev;
  logic               rx_ovf_q;
  logic               rx_unf_q;

  byte_t              tx_head;
  logic [`CNT_W-1:0]  tx_count;
  logic               tx_full;
  logic               tx_empty;
  logic               tx_push;
  logic               tx_flush;
  logic               tx_take;
  logic               tx_gated;
  logic               tx_ovf_ev;
  logic               tx_ovf_q;
  logic               tx_valid_q;
  logic               tx_gate_q;

  byte_t              rx_maxpkt_q;
  byte_t              tx_maxpkt_q;
  logic [`IRQ_W-1:0]  irq_ev;
  logic [`IRQ_W-1:0]  irq_clr;
  logic [`IRQ_W-1:0]  irq_stat_q;
  logic [`IRQ_W-1:0]  irq_mask_q;
  logic               irq_q;
  logic               out_nak_q;
  host_in_rsp_s       in_rsp_q;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then commit
  // ----------------------------------------------------------------
  // Side effects happen only at the edge where waitrequest is seen low
  assign commit    = (bus_q == BUS_ACK);
  assign wr_commit = commit && avs_write && avs_byteenable[0];
  assign rd_commit = commit && avs_read;
  assign wbyte     = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_q         <= BUS_IDLE;
      waitrequest_q <= 1'b1;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q         <= BUS_ACK;
            waitrequest_q <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_q         <= BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
        default: begin
          bus_q         <= BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (is_reg(avs_address, `RX_DATA_IDX)) begin
      rd_byte = rx_empty ? 8'h00 : rx_head;
    end else if (is_reg(avs_address, `RX_COUNT_IDX)) begin
      rd_byte = {1'b0, rx_count};
    end else if (is_reg(avs_address, `RX_STATUS_IDX)) begin
      // Flush bit stays zero on read
      rd_byte[`ST_OVF_BIT]   = rx_ovf_q;
      rd_byte[`ST_UNF_BIT]   = rx_unf_q;
      rd_byte[`ST_FULL_BIT]  = rx_full;
      rd_byte[`ST_EMPTY_BIT] = rx_empty;
    end else if (is_reg(avs_address, `RX_MAXPKT_IDX)) begin
      rd_byte = rx_maxpkt_q;
    end else if (is_reg(avs_address, `TX_COUNT_IDX)) begin
      rd_byte = {1'b0, tx_count};
    end else if (is_reg(avs_address, `TX_STATUS_IDX)) begin
      // Flush and reserved bits stay zero on read
      rd_byte[`ST_TXVLD_BIT] = tx_valid_q;
      rd_byte[`ST_OVF_BIT]   = tx_ovf_q;
      rd_byte[`ST_FULL_BIT]  = tx_full;
      rd_byte[`ST_EMPTY_BIT] = tx_empty;
    end else if (is_reg(avs_address, `TX_MAXPKT_IDX)) begin
      rd_byte = tx_maxpkt_q;
    end else if (is_reg(avs_address, `IRQ_STAT_IDX)) begin
      rd_byte = {3'b000, irq_stat_q};
    end else if (is_reg(avs_address, `IRQ_MASK_IDX)) begin
      rd_byte = {3'b000, irq_mask_q};
    end else if (is_reg(avs_address, `TX_GATE_IDX)) begin
      rd_byte = {7'b0000000, tx_gate_q};
    end
  end

  // Captured one cycle before commit; nothing else pops the receive head
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata_q <= 32'h00000000;
    end else if (bus_q == BUS_IDLE && avs_read) begin
      readdata_q <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 3 receive FIFO
  // ----------------------------------------------------------------
  assign rx_pop    = rd_commit && is_reg(avs_address, `RX_DATA_IDX);
  assign rx_flush  = wr_commit && is_reg(avs_address, `RX_STATUS_IDX)
                     && wbyte[`ST_FLUSH_BIT];
  assign rx_ovf_ev = host_out.valid && rx_full;
  assign rx_unf_ev = rx_pop && rx_empty;

  byte_fifo u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (host_out.valid),
    .push_data (host_out.data),
    .pop       (rx_pop),
    .flush     (rx_flush),
    .head      (rx_head),
    .count_q   (rx_count),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_ovf_q <= 1'b0;
      rx_unf_q <= 1'b0;
    end else begin
      rx_ovf_q <= rx_ovf_ev || (rx_ovf_q && !(wr_commit
                  && is_reg(avs_address, `RX_STATUS_IDX) && wbyte[`ST_OVF_BIT]));
      rx_unf_q <= rx_unf_ev || (rx_unf_q && !(wr_commit
                  && is_reg(avs_address, `RX_STATUS_IDX) && wbyte[`ST_UNF_BIT]));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_nak_q <= 1'b0;
    end else begin
      out_nak_q <= rx_ovf_ev;
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 4 transmit FIFO
  // ----------------------------------------------------------------
  assign tx_push   = wr_commit && is_reg(avs_address, `TX_DATA_IDX);
  assign tx_flush  = wr_commit && is_reg(avs_address, `TX_STATUS_IDX)
                     && wbyte[`ST_FLUSH_BIT];
  assign tx_ovf_ev = tx_push && tx_full;
  // Without the gate bit, transmit-valid is ignored
  assign tx_gated  = tx_gate_q && !tx_valid_q;
  assign tx_take   = host_in_req.req && !tx_gated && !tx_empty;

  byte_fifo u_tx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (tx_push),
    .push_data (wbyte),
    .pop       (tx_take),
    .flush     (tx_flush),
    .head      (tx_head),
    .count_q   (tx_count),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_ovf_q <= 1'b0;
    end else begin
      tx_ovf_q <= tx_ovf_ev || (tx_ovf_q && !(wr_commit
                  && is_reg(avs_address, `TX_STATUS_IDX) && wbyte[`ST_OVF_BIT]));
    end
  end

  // Software write beats the self-clear so a re-arm is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_valid_q <= 1'b0;
    end else if (wr_commit && is_reg(avs_address, `TX_STATUS_IDX)) begin
      tx_valid_q <= wbyte[`ST_TXVLD_BIT];
    end else if (tx_take && host_in_req.last) begin
      tx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_gate_q <= 1'b0;
    end else if (wr_commit && is_reg(avs_address, `TX_GATE_IDX)) begin
      tx_gate_q <= wbyte[`TX_GATE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_rsp_q <= '0;
    end else begin
      in_rsp_q.ack  <= tx_take;
      in_rsp_q.nak  <= host_in_req.req && !tx_take;
      in_rsp_q.data <= tx_take ? tx_head : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Max packet size, units of eight bytes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_maxpkt_q <= `MAXPKT_RST;
    end else if (wr_commit && is_reg(avs_address, `RX_MAXPKT_IDX)) begin
      rx_maxpkt_q <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_maxpkt_q <= `MAXPKT_RST;
    end else if (wr_commit && is_reg(avs_address, `TX_MAXPKT_IDX)) begin
      tx_maxpkt_q <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    irq_ev              = '0;
    irq_ev[`IRQ_RX_OVF]  = rx_ovf_ev;
    irq_ev[`IRQ_RX_UNF]  = rx_unf_ev;
    irq_ev[`IRQ_TX_OVF]  = tx_ovf_ev;
    irq_ev[`IRQ_RX_DATA] = host_out.valid && !rx_full;
    irq_ev[`IRQ_TX_SENT] = tx_take;
  end

  assign irq_clr = (wr_commit && is_reg(avs_address, `IRQ_STAT_IDX))
                   ? wbyte[`IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (wr_commit && is_reg(avs_address, `IRQ_MASK_IDX)) begin
      irq_mask_q <= wbyte[`IRQ_W-1:0];
    end
  end

  // Registered, so it trails the status bit by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = waitrequest_q;
  assign irq             = irq_q;
  assign host_out_nak    = out_nak_q;
  assign host_in_rsp     = in_rsp_q;
  assign ep3_max_pkt     = rx_maxpkt_q;
  assign ep4_max_pkt     = tx_maxpkt_q;

endmodule

// ==== usb_bulk_endpoint_fifos_assertions.sv ====
// Purpose: Port-level checks for the bulk endpoint FIFO block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to the top module from the bench top file.
`timescale 1ns/1ps
`include "usb_ep_consts.svh"
module usb_ep_checker (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [`ADDR_W-1:0]   avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input usb_ep_pkg::host_out_s     host_out,
  input wire logic                 host_out_nak,
  input usb_ep_pkg::host_in_req_s  host_in_req,
  input usb_ep_pkg::host_in_rsp_s  host_in_rsp,
  input usb_ep_pkg::byte_t         ep3_max_pkt,
  input usb_ep_pkg::byte_t         ep4_max_pkt
);
  import usb_ep_pkg::*;

  logic req;
  logic w3;
  logic w4;
  assign req = avs_read | avs_write;
  assign w3  = avs_write && avs_address == `RX_MAXPKT_IDX;
  assign w4  = avs_write && avs_address == `TX_MAXPKT_IDX;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  a_bus_answer_next: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_bus_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_bus_ack_cause: assert property (!avs_waitrequest |-> $past(req))
    else $error("waitrequest low without a request");
  a_rdata_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // Size ports may only move after a write to their own register
  a_ep3_size_source: assert property ($changed(ep3_max_pkt) |-> $past(w3) || $past(w3, 2))
    else $error("endpoint 3 size changed without a write");
  a_ep4_size_source: assert property ($changed(ep4_max_pkt) |-> $past(w4) || $past(w4, 2))
    else $error("endpoint 4 size changed without a write");

  // ------------------------------------------------------------------
  // Host side
  // ------------------------------------------------------------------
  a_in_one_answer: assert property (host_in_req.req |=> host_in_rsp.ack != host_in_rsp.nak)
    else $error("IN request without exactly one answer");
  a_in_answer_cause: assert property (host_in_rsp.ack || host_in_rsp.nak |-> $past(host_in_req.req))
    else $error("IN answer without request");
  a_in_nak_no_data: assert property (host_in_rsp.nak |-> host_in_rsp.data == 8'h00 && !host_in_rsp.ack)
    else $error("refused IN answer carries data");
  a_out_nak_cause: assert property (host_out_nak |-> $past(host_out.valid))
    else $error("OUT refusal without an OUT byte");

  c_out_refused: cover property (host_out_nak);
  c_in_last_acked: cover property (host_in_rsp.ack && $past(host_in_req.last));
  c_in_refused: cover property (host_in_rsp.nak);
endmodule

// ==== usb_host_model.sv ====
// Purpose: Behavioural USB host driving the endpoint 3 and 4 byte streams.
// Assumes: Host engine runs on the block clock.
// Notes:   Responses are judged by the bench, not here.
`timescale 1ns/1ps
module usb_host_model (
  input wire logic                 clk,
  output usb_ep_pkg::host_out_s    host_out,
  output usb_ep_pkg::host_in_req_s host_in_req
);
  import usb_ep_pkg::*;

  initial begin
    host_out    = '0;
    host_in_req = '0;
  end

  // One-cycle OUT byte; idle data inverted so stale bytes never look valid
  task automatic send_out(input byte_t d);
    @(posedge clk);
    host_out <= '{valid: 1'b1, data: d};
    @(posedge clk);
    host_out <= '{valid: 1'b0, data: ~d};
  endtask

  task automatic ask_in(input logic last);
    @(posedge clk);
    host_in_req <= '{req: 1'b1, last: last};
    @(posedge clk);
    host_in_req <= '{req: 1'b0, last: 1'b0};
  endtask
endmodule

// ==== usb_bulk_endpoint_fifos_bench.sv ====
// Purpose: Self-checking bench for the bulk endpoint FIFO block.
// Assumes: Avalon-MM master with one request in flight.
// Notes:   Expected results queue up; negedge watchers compare them.
`timescale 1ns/1ps
`include "usb_ep_consts.svh"
module usb_bulk_endpoint_fifos_bench;
  import usb_ep_pkg::*;

  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [15:0]   avs_address = '0;
  logic [31:0]   avs_writedata = '0;
  logic [3:0]    avs_byteenable = 4'hF;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          irq;
  logic          host_out_nak;
  host_out_s     host_out;
  host_in_req_s  host_in_req;
  host_in_rsp_s  host_in_rsp;
  byte_t         ep3_max_pkt;
  byte_t         ep4_max_pkt;
  logic [31:0]   rd_q[$];
  logic [9:0]    in_q[$];
  byte_t         dq[$];
  int            n_errors = 0;
  int            n_tests = 0;
  int            n_nak = 0;
  int            cyc = 0;
  logic [15:0]   ra[8] = '{`RX_COUNT_IDX, `RX_STATUS_IDX, `RX_MAXPKT_IDX, `TX_DATA_IDX,
                           `TX_COUNT_IDX, `TX_STATUS_IDX, `TX_MAXPKT_IDX, 16'h4030};
  byte_t         rv[8] = '{8'h00, 8'h01, 8'h08, 8'h00, 8'h00, 8'h01, 8'h08, 8'h00};

  always #5 clk = ~clk;

  usb_bulk_endpoint_fifos usb_bulk_endpoint_fifos_i (.clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
    .host_out, .host_out_nak, .host_in_req, .host_in_rsp, .ep3_max_pkt, .ep4_max_pkt);
  usb_host_model usb_host_model_i (.clk, .host_out, .host_in_req);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge, then released
  task automatic bus(input logic w, input logic [15:0] a, input byte_t d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input byte_t e);
    rd_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [15:0] a, input byte_t d);
    bus(1'b1, a, d);
  endtask

  task automatic hin(input logic last, input logic [9:0] e);
    in_q.push_back(e);
    usb_host_model_i.ask_in(last);
  endtask

  // Irq is registered one cycle behind its cause
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk("irq", e, irq);
  endtask

  task automatic done(input string s);
    $display("Test %s finished, mismatches %0d", s, n_errors);
  endtask

  always @(negedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk("readdata", rd_q.pop_front(), avs_readdata);
    if ((host_in_rsp.ack | host_in_rsp.nak) === 1'b1)
      chk("in response", {22'h0, in_q.pop_front()}, {22'h0, host_in_rsp});
    if (host_out_nak === 1'b1)
      n_nak++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    byte_t b;
    void'($urandom(32'h996969aa));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    chk("irq idle", 32'h0, {31'h0, irq});
    done("reset");
    b = 8'($urandom);
    wr(`RX_MAXPKT_IDX, b);
    rd(`RX_MAXPKT_IDX, b);
    chk("ep3 size", {24'h0, b}, {24'h0, ep3_max_pkt});
    b = 8'($urandom);
    wr(`TX_MAXPKT_IDX, b);
    rd(`TX_MAXPKT_IDX, b);
    chk("ep4 size", {24'h0, b}, {24'h0, ep4_max_pkt});
    // Low byte lane disabled: the write must leave the size alone
    avs_byteenable <= 4'hE;
    wr(`TX_MAXPKT_IDX, ~b);
    avs_byteenable <= 4'hF;
    rd(`TX_MAXPKT_IDX, b);
    done("packet size");
    for (int i = 0; i < 65; i++) begin
      b = 8'($urandom);
      if (i < 64) dq.push_back(b);
      usb_host_model_i.send_out(b);
    end
    rd(`RX_COUNT_IDX, 8'h40);
    rd(`RX_STATUS_IDX, 8'h0A);
    chk("out refusals", 32'd1, n_nak);
    rd(`IRQ_STAT_IDX, 8'h09);
    irq_is(1'b0);
    wr(`IRQ_MASK_IDX, 8'h01);
    irq_is(1'b1);
    wr(`RX_STATUS_IDX, 8'h08);
    rd(`RX_STATUS_IDX, 8'h02);
    wr(`IRQ_STAT_IDX, 8'h09);
    irq_is(1'b0);
    done("rx fill");
    for (int i = 0; i < 64; i++) rd(`RX_DATA_IDX, dq.pop_front());
    rd(`RX_DATA_IDX, 8'h00);
    rd(`RX_STATUS_IDX, 8'h05);
    wr(`RX_STATUS_IDX, 8'h04);
    rd(`RX_STATUS_IDX, 8'h01);
    repeat (3) usb_host_model_i.send_out(8'hA5);
    rd(`RX_COUNT_IDX, 8'h03);
    wr(`RX_STATUS_IDX, 8'h10);
    rd(`RX_COUNT_IDX, 8'h00);
    rd(`RX_STATUS_IDX, 8'h01);
    done("rx drain");
    for (int i = 0; i < 65; i++) begin
      b = 8'($urandom);
      if (i < 64) dq.push_back(b);
      wr(`TX_DATA_IDX, b);
    end
    rd(`TX_COUNT_IDX, 8'h40);
    rd(`TX_STATUS_IDX, 8'h0A);
    wr(`TX_STATUS_IDX, 8'h08);
    for (int i = 0; i < 64; i++) hin(1'b0, {2'b10, dq.pop_front()});
    hin(1'b0, 10'h100);
    rd(`TX_STATUS_IDX, 8'h01);
    rd(`TX_COUNT_IDX, 8'h00);
    rd(`IRQ_STAT_IDX, 8'h1E);
    wr(`IRQ_STAT_IDX, 8'h1E);
    rd(`IRQ_STAT_IDX, 8'h00);
    done("tx fill");
    wr(`TX_GATE_IDX, 8'h01);
    wr(`TX_DATA_IDX, 8'h3C);
    wr(`TX_DATA_IDX, 8'hC3);
    hin(1'b1, 10'h100);
    wr(`TX_STATUS_IDX, 8'h20);
    rd(`TX_STATUS_IDX, 8'h20);
    hin(1'b1, {2'b10, 8'h3C});
    rd(`TX_STATUS_IDX, 8'h00);
    hin(1'b0, 10'h100);
    wr(`TX_GATE_IDX, 8'h00);
    hin(1'b0, {2'b10, 8'hC3});
    wr(`TX_DATA_IDX, 8'h11);
    wr(`TX_DATA_IDX, 8'h22);
    wr(`TX_STATUS_IDX, 8'h10);
    rd(`TX_COUNT_IDX, 8'h00);
    rd(`TX_STATUS_IDX, 8'h01);
    done("tx gate and flush");
    repeat (4) @(posedge clk);
    chk("pending results", 32'h0, rd_q.size() + in_q.size());
    stop_test();
  end
endmodule

bind usb_bulk_endpoint_fifos usb_ep_checker usb_ep_checker_i (.clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .host_out, .host_out_nak,
  .host_in_req, .host_in_rsp, .ep3_max_pkt, .ep4_max_pkt);
